/* File: rtl/tcsd_cfg.svh */
// field positions, limits and reset values of the texel block decoder
`ifndef TCSD_CFG_SVH
`define TCSD_CFG_SVH
`define TCSD_BASE_MSB 63
`define TCSD_BASE_LSB 56
`define TCSD_MULT_MSB 55
`define TCSD_MULT_LSB 52
`define TCSD_TABLE_MSB 51
`define TCSD_TABLE_LSB 48
`define TCSD_INDEX_MSB 47
`define TCSD_INDEX_LSB 45
`define TCSD_INDEX_STEP 6'h03
`define TCSD_SCALE_SHIFT 3
`define TCSD_ROUND_BITS 3'h4
`define TCSD_BASE_FORBID 8'h80
`define TCSD_BASE_SUBST 14'sh3f81
`define TCSD_SIGNED_MAX 14'sh03ff
`define TCSD_SIGNED_MIN 14'sh3c01
`define TCSD_UNSIGNED_MAX 14'sh07ff
`define TCSD_UNSIGNED_MIN 14'sh0000
`define TCSD_SUM_W 14
`define TCSD_NARROW_RST 11'h000
`endif

/* File: rtl/tcsd_pkg.sv */
// types and shared decode functions of the texel block decoder
`include "tcsd_cfg.svh"
package tcsd_pkg;
	// block format requested by the sampling pipeline
	typedef enum logic [1:0] {
		one_channel_unsigned_format = 2'h0,
		one_channel_signed_format = 2'h1,
		two_channel_unsigned_format = 2'h2,
		two_channel_signed_format = 2'h3
	} tcsd_format_t;
	// sequencer states of the top module
	typedef enum logic [1:0] {st_idle, st_calc, st_load, st_resp} tcsd_state_t;
	// sixteen block bytes, element i is the byte at address offset i
	typedef logic [15:0][7:0] tcsd_block_t;
	typedef logic signed [`TCSD_SUM_W-1:0] tcsd_sum_t;
	// negative magnitudes of the sixteen tables, entry 0 leftmost nibble
	// selector 13 sits third in the list: -1 -2 -3 -10 0 1 2 9
	localparam logic [15:0][15:0] TCSD_MAGS = {
		16'h3579, 16'h4689, 16'h123a, 16'h347a,
		16'h257a, 16'h248a, 16'h258a, 16'h268a,
		16'h358b, 16'h478b, 16'h379b, 16'h368c,
		16'h246d, 16'h258d, 16'h37ad, 16'h369f};
	// table entry: low half is -m, high half mirrors it as m-1
	function automatic logic signed [4:0] tcsd_modifier(
		input logic [3:0] sel, input logic [2:0] idx);
		logic [15:0] row;
		logic [3:0] mag;
		row = TCSD_MAGS[sel];
		mag = row[{~idx[1:0], 2'h0} +: 4];
		if (idx[2]) begin
			return 5'($signed({1'b0, mag}) - 5'sh01);
		end
		return 5'(-$signed({1'b0, mag}));
	endfunction
	// index of texel n sits at bits 47-3n .. 45-3n, msb first
	function automatic logic [2:0] tcsd_texel_index(
		input logic [63:0] word, input logic [3:0] texel);
		logic [47:0] bits;
		bits = word[`TCSD_INDEX_MSB:0] << (`TCSD_INDEX_STEP * {2'h0, texel});
		return bits[`TCSD_INDEX_MSB:`TCSD_INDEX_LSB];
	endfunction
	// saturate the wide sum to the format's 11-bit range
	function automatic logic [10:0] tcsd_eleven_bit_saturate(
		input tcsd_sum_t sum, input logic is_signed);
		tcsd_sum_t lo;
		tcsd_sum_t hi;
		lo = is_signed ? `TCSD_SIGNED_MIN : `TCSD_UNSIGNED_MIN;
		hi = is_signed ? `TCSD_SIGNED_MAX : `TCSD_UNSIGNED_MAX;
		if (sum < lo) begin
			return 11'(lo);
		end
		if (sum > hi) begin
			return 11'(hi);
		end
		return 11'(sum);
	endfunction
	function automatic logic tcsd_fmt_signed(input tcsd_format_t f);
		return f[0];
	endfunction
	function automatic logic tcsd_fmt_dual(input tcsd_format_t f);
		return f[1];
	endfunction
endpackage

/* File: rtl/tcsd_lane_if.sv */
// one decode lane: block word and texel in, narrow and widened value out
`timescale 1ns/1ns
`default_nettype none
interface tcsd_lane_if;
	logic [63:0] word; // assembled 64-bit block word
	logic [3:0] texel; // texel position 0..15
	logic is_signed; // signed arithmetic, one- or two-channel formats
	logic [10:0] narrow; // registered 11-bit result
	logic [15:0] wide16; // widened copy, 16 bits
	logic [31:0] wide32; // widened copy, 32 bits
	modport core (input word, texel, is_signed, output narrow);
	modport widen (input is_signed, narrow, output wide16, wide32);
	modport owner (output word, texel, is_signed, input narrow, wide16, wide32);
endinterface
`default_nettype wire

/* File: rtl/tcsd_texel_core.sv */
// one-word texel decoder shared by the signed and unsigned paths
`timescale 1ns/1ns
`default_nettype none
`include "tcsd_cfg.svh"
module tcsd_texel_core (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// lane
	tcsd_lane_if.core lane
);
	import tcsd_pkg::*;
	typedef struct packed {
		logic [10:0] narrow;
	} tcsd_core_t;
	tcsd_core_t cur; // registered result
	tcsd_core_t next_cur;
	tcsd_sum_t base_s; // scaled base
	tcsd_sum_t term_s; // scaled modifier term
	logic signed [4:0] mod; // table entry
	logic signed [9:0] prod; // modifier times multiplier
	logic [7:0] code;
	logic [3:0] mult;
	// one datapath for both formats, only base decode (sign, -128 pin, offset) and limits differ
	always_comb begin
		next_cur = cur;
		code = lane.word[`TCSD_BASE_MSB:`TCSD_BASE_LSB];
		mult = lane.word[`TCSD_MULT_MSB:`TCSD_MULT_LSB];
		mod = tcsd_modifier(lane.word[`TCSD_TABLE_MSB:`TCSD_TABLE_LSB],
			tcsd_texel_index(lane.word, lane.texel));
		if (lane.is_signed) begin
			// -128 would reach past -1.0, so it is pinned to -127
			base_s = (code == `TCSD_BASE_FORBID) ? `TCSD_BASE_SUBST :
				14'($signed(code));
			base_s = base_s <<< `TCSD_SCALE_SHIFT;
		end else begin
			// rounding offset comes free as the low three bits
			base_s = $signed({3'h0, code, `TCSD_ROUND_BITS});
		end
		prod = mod * $signed({1'b0, mult});
		if (mult == 4'h0) begin
			term_s = 14'(mod);
		end else begin
			term_s = 14'(prod) <<< `TCSD_SCALE_SHIFT;
		end
		next_cur.narrow = tcsd_eleven_bit_saturate(base_s + term_s,
			lane.is_signed);
	end
	// result register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cur <= '{narrow: `TCSD_NARROW_RST};
		end else begin
			cur <= next_cur;
		end
	end
	assign lane.narrow = cur.narrow;
endmodule // tcsd_texel_core
`default_nettype wire

/* File: rtl/tcsd_widen.sv */
// sign-aware bit replication of an 11-bit result to 16 and 32 bits
`timescale 1ns/1ns
`default_nettype none
module tcsd_widen (
	// lane
	tcsd_lane_if.widen lane
);
	logic neg; // negative signed value
	logic [10:0] mag; // magnitude that gets replicated
	logic [15:0] m16;
	logic [31:0] m32;
	// replicating a negative code directly gives wrong levels
	always_comb begin
		neg = lane.is_signed & lane.narrow[10];
		mag = neg ? 11'(-lane.narrow) : lane.narrow;
		if (lane.is_signed) begin
			m16 = {1'b0, mag[9:0], mag[9:5]};
			m32 = {1'b0, mag[9:0], mag[9:0], mag[9:0], mag[9]};
		end else begin
			m16 = {mag, mag[10:6]};
			m32 = {mag, mag, mag[10:1]};
		end
		lane.wide16 = neg ? 16'(-m16) : m16;
		lane.wide32 = neg ? 32'(-m32) : m32;
	end
endmodule // tcsd_widen
`default_nettype wire

/* File: rtl/tcsd_decoder.sv */
// texel block decoder top: request handshake, byte order, two lanes
`timescale 1ns/1ns
`default_nettype none
module tcsd_decoder (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// request from the sampling pipeline
	input wire logic req_valid,
	output logic req_ready,
	input wire tcsd_pkg::tcsd_block_t req_block,
	input wire tcsd_pkg::tcsd_format_t req_format,
	input wire logic [3:0] req_texel,
	// decoded answer
	input wire logic rsp_ready,
	output logic rsp_valid,
	output logic [10:0] rsp_red_narrow,
	output logic [10:0] rsp_green_narrow,
	output logic [15:0] rsp_red_wide16,
	output logic [15:0] rsp_green_wide16,
	output logic [31:0] rsp_red_wide32,
	output logic [31:0] rsp_green_wide32
);
	import tcsd_pkg::*;

	// whole state of the top in one record
	typedef struct packed {
		tcsd_state_t state; // sequencer
		logic req_ready; // open for a request
		logic rsp_valid; // answer on the outputs
		tcsd_format_t fmt; // latched block format
		logic [3:0] texel; // latched texel position
		logic [63:0] word0; // first block word, red
		logic [63:0] word1; // second block word, green
		logic [10:0] red_n;
		logic [10:0] green_n;
		logic [15:0] red_w16;
		logic [15:0] green_w16;
		logic [31:0] red_w32;
		logic [31:0] green_w32;
	} tcsd_top_t;

	tcsd_top_t r; // registered state
	tcsd_top_t next_r; // next state

	// two lanes so both channels of a block finish together
	tcsd_lane_if red_lane();
	tcsd_lane_if green_lane();

	// lane inputs come straight from latched state, so they hold still
	// for the whole decode and the cores need no enable
	assign red_lane.word = r.word0;
	assign red_lane.texel = r.texel;
	assign red_lane.is_signed = tcsd_fmt_signed(r.fmt);
	assign green_lane.word = r.word1;
	assign green_lane.texel = r.texel;
	assign green_lane.is_signed = tcsd_fmt_signed(r.fmt);

	// red channel decoder
	tcsd_texel_core u_red_core (
		.clk_sys(clk_sys),
		.rst(rst),
		.lane(red_lane)
	);
	// green channel decoder, idle work for one-channel blocks
	tcsd_texel_core u_green_core (
		.clk_sys(clk_sys),
		.rst(rst),
		.lane(green_lane)
	);
	// widening of the registered red result
	tcsd_widen u_red_widen (
		.lane(red_lane)
	);
	// widening of the registered green result
	tcsd_widen u_green_widen (
		.lane(green_lane)
	);

	// sequencer: accept, let the cores settle, load outputs, hold
	always_comb begin
		next_r = r;
		case (r.state)
			st_idle: begin
				next_r.req_ready = 1'b1;
				if (req_valid && r.req_ready) begin
					// format and texel travel with the block
					next_r.fmt = req_format;
					next_r.texel = req_texel;
					// lowest address lands in the top byte of each word
					for (int i = 0; i < 8; i++) begin
						next_r.word0[8 * (7 - i) +: 8] = req_block[i];
						next_r.word1[8 * (7 - i) +: 8] = req_block[i + 8];
					end
					next_r.req_ready = 1'b0;
					next_r.state = st_calc;
				end
			end
			st_calc: begin
				// cores register their result on this edge
				next_r.state = st_load;
			end
			st_load: begin
				next_r.red_n = red_lane.narrow;
				next_r.red_w16 = red_lane.wide16;
				next_r.red_w32 = red_lane.wide32;
				if (tcsd_fmt_dual(r.fmt)) begin
					next_r.green_n = green_lane.narrow;
					next_r.green_w16 = green_lane.wide16;
					next_r.green_w32 = green_lane.wide32;
				end else begin
					// one-channel blocks carry no green data
					next_r.green_n = 11'h000;
					next_r.green_w16 = 16'h0000;
					next_r.green_w32 = 32'h00000000;
				end
				next_r.rsp_valid = 1'b1;
				next_r.state = st_resp;
			end
			st_resp: begin
				// answer holds until the pipeline takes it
				if (rsp_ready) begin
					next_r.rsp_valid = 1'b0;
					next_r.req_ready = 1'b1;
					next_r.state = st_idle;
				end
			end
			default: begin
				next_r.state = st_idle;
			end
		endcase
	end

	// state register, everything cleared on reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// every output comes straight from the state record
	assign req_ready = r.req_ready;
	assign rsp_valid = r.rsp_valid;
	assign rsp_red_narrow = r.red_n;
	assign rsp_green_narrow = r.green_n;
	assign rsp_red_wide16 = r.red_w16;
	assign rsp_green_wide16 = r.green_w16;
	assign rsp_red_wide32 = r.red_w32;
	assign rsp_green_wide32 = r.green_w32;

	// checks on the decode, clocked on the system clock
	default clocking tcsd_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// helper views of the latched red word
	logic [15:0] red_head; // base, multiplier and table fields
	logic [2:0] red_idx; // index of the latched texel
	logic calc_signed; // signed decode in progress
	logic calc_unsigned; // unsigned decode in progress
	assign red_head = r.word0[63:48];
	assign red_idx = tcsd_texel_index(r.word0, r.texel);
	assign calc_signed = (r.state == st_calc) && tcsd_fmt_signed(r.fmt);
	assign calc_unsigned = (r.state == st_calc) && !tcsd_fmt_signed(r.fmt);

	// one answer, three edges after the request is taken
	a_one_answer: assert property (
		req_valid && req_ready |=> !rsp_valid [*2] ##1 rsp_valid)
		else $error("answer not three cycles after accept");

	// answer stands still while the pipeline stalls
	a_hold_answer: assert property (
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_red_narrow)
			&& $stable(rsp_green_wide16) && !req_ready)
		else $error("answer changed or dropped during stall");

	// first address byte tops the first word, last byte ends the second word
	a_byte_order: assert property (
		req_valid && req_ready |=> r.word0[63:56] == $past(req_block[0])
			&& r.word1[7:0] == $past(req_block[15]))
		else $error("block bytes assembled in wrong order");

	// forbidden base is pinned to -127, so -127*8 with a zero entry
	a_base_pinned: assert property (
		calc_signed && red_head == 16'h800d && red_idx == 3'h4
		|=> red_lane.narrow == 11'h408)
		else $error("signed base -128 not treated as -127");

	// signed example with multiplier two gives 320
	a_signed_scaled: assert property (
		calc_signed && red_head == 16'h3c2d && red_idx == 3'h3
		|=> red_lane.narrow == 11'h140)
		else $error("signed scaled decode wrong");

	// zero multiplier adds the raw entry: 480 - 10
	a_signed_zero_mult: assert property (
		calc_signed && red_head == 16'h3c0d && red_idx == 3'h3
		|=> red_lane.narrow == 11'h1d6)
		else $error("signed zero multiplier decode wrong");

	// unsigned base carries the +4 offset: 828 - 160
	a_unsigned_round: assert property (
		calc_unsigned && red_head == 16'h672d && red_idx == 3'h3
		|=> red_lane.narrow == 11'h29c)
		else $error("unsigned decode wrong");

	// unsigned zero multiplier: 828 - 10
	a_unsigned_zero_mult: assert property (
		calc_unsigned && red_head == 16'h670d && red_idx == 3'h3
		|=> red_lane.narrow == 11'h332)
		else $error("unsigned zero multiplier decode wrong");

	// signed answers never show -1024
	a_signed_clamp: assert property (
		rsp_valid && tcsd_fmt_signed(r.fmt)
		|-> rsp_red_narrow != 11'h400 && rsp_green_narrow != 11'h400)
		else $error("signed result outside -1023..1023");

	// unsigned answers saturate at the top, never wrap; the zero entry of
	// selector 13 would land on 2044, so it is left out
	a_unsigned_top: assert property (
		calc_unsigned && r.word0[63:52] == 12'hfff && red_idx[2]
		&& !(red_idx == 3'h4 && r.word0[51:48] == 4'hd)
		|=> red_lane.narrow == 11'h7ff)
		else $error("unsigned sum not saturated at 2047");

	// unsigned answers saturate at the bottom: 4 - 1200 gives 0
	a_unsigned_floor: assert property (
		calc_unsigned && red_head == 16'h00fd && red_idx == 3'h3
		|=> red_lane.narrow == 11'h000)
		else $error("unsigned sum not saturated at 0");

	// signed sum saturates at -1023: -1016 - 1200
	a_signed_floor: assert property (
		calc_signed && red_head == 16'h81fd && red_idx == 3'h3
		|=> red_lane.narrow == 11'h401)
		else $error("signed sum not saturated at -1023");

	// signed sum saturates at 1023: 1016 + 1080
	a_signed_top: assert property (
		calc_signed && red_head == 16'h7ffd && red_idx == 3'h7
		|=> red_lane.narrow == 11'h3ff)
		else $error("signed sum not saturated at 1023");

	// no request is taken while a decode is under way
	a_ready_busy: assert property (
		r.state != st_idle |-> !req_ready)
		else $error("ready raised during a decode");

	// an answer only stands in the answer state
	a_valid_resp: assert property (
		rsp_valid |-> r.state == st_resp)
		else $error("answer shown outside the answer state");

	// a taken answer drops and reopens the request side
	a_answer_release: assert property (
		rsp_valid && rsp_ready |=> !rsp_valid && req_ready)
		else $error("answer not released after handshake");

	// last byte of the first word and first byte of the second
	a_byte_tail: assert property (
		req_valid && req_ready |=> r.word0[7:0] == $past(req_block[7])
			&& r.word1[63:56] == $past(req_block[8]))
		else $error("block word boundary in wrong place");

	// format and texel position are latched with the block
	a_fmt_latched: assert property (
		req_valid && req_ready |=> r.fmt == $past(req_format)
			&& r.texel == $past(req_texel))
		else $error("format or texel not latched");

	// the second texel reads bits 44..42
	a_texel_b: assert property (
		r.state == st_calc && r.texel == 4'h1
		|-> red_idx == r.word0[44:42])
		else $error("second texel index taken from wrong bits");

	// widened signed copies keep the sign of the narrow result
	a_wide_sign: assert property (
		rsp_valid && tcsd_fmt_signed(r.fmt)
		|-> rsp_red_wide16[15] == rsp_red_narrow[10]
			&& rsp_red_wide32[31] == rsp_red_narrow[10])
		else $error("signed widening lost the sign");

	// green widening follows the same sign rule
	a_green_sign: assert property (
		rsp_valid && r.fmt == two_channel_signed_format
		|-> rsp_green_wide16[15] == rsp_green_narrow[10])
		else $error("green signed widening lost the sign");

	// green 32-bit copy keeps all eleven bits
	a_green_keeps: assert property (
		rsp_valid && r.fmt == two_channel_unsigned_format
		|-> rsp_green_wide32[31:21] == rsp_green_narrow)
		else $error("green 32-bit copy lost precision");

	// positive and negative signed widening
	a_widen_signed: assert property (
		rsp_valid && tcsd_fmt_signed(r.fmt) && rsp_red_narrow == 11'h1d6
		|-> rsp_red_wide16 == 16'h3ace)
		else $error("positive signed widening wrong");
	a_widen_negative: assert property (
		rsp_valid && tcsd_fmt_signed(r.fmt) && rsp_red_narrow == 11'h62a
		|-> rsp_red_wide16 == 16'hc532 && rsp_red_wide32[31])
		else $error("negative signed widening wrong");

	// unsigned widening replicates the top five bits
	a_widen_unsigned: assert property (
		rsp_valid && !tcsd_fmt_signed(r.fmt) && rsp_red_narrow == 11'h29c
		|-> rsp_red_wide16 == 16'h538a)
		else $error("unsigned widening wrong");

	// unsigned 32-bit copies keep all eleven bits of the result
	a_wide_keeps: assert property (
		rsp_valid && !tcsd_fmt_signed(r.fmt)
		|-> rsp_red_wide32[31:21] == rsp_red_narrow)
		else $error("32-bit copy lost precision");

	// one-channel answers leave green at zero
	a_green_quiet: assert property (
		rsp_valid && !tcsd_fmt_dual(r.fmt) |-> rsp_green_narrow == 11'h000)
		else $error("green set for one-channel block");

	// main scenarios
	c_accept: cover property (req_valid && req_ready);
	c_stall: cover property (rsp_valid && !rsp_ready ##1 rsp_valid && rsp_ready);
	c_dual_signed: cover property (rsp_valid && r.fmt == two_channel_signed_format);
	c_saturated: cover property (rsp_valid && rsp_red_narrow == 11'h3ff);
endmodule // tcsd_decoder
`default_nettype wire

/* File: sim/tcsd_pipe_model.sv */
// sampling pipeline model: presents blocks and takes the answers
`timescale 1ns/1ns
`default_nettype none
module tcsd_pipe_model (
	// clock
	input wire logic clk_sys,
	// request side
	input wire logic req_ready,
	output var logic req_valid,
	output var tcsd_pkg::tcsd_block_t req_block,
	output var tcsd_pkg::tcsd_format_t req_format,
	output var logic [3:0] req_texel,
	// answer side
	input wire logic rsp_valid,
	output var logic rsp_ready
);
	import tcsd_pkg::*;

	// idle until the bench asks for a fetch
	initial begin
		req_valid = 1'b0;
		req_block = '0;
		req_format = one_channel_unsigned_format;
		req_texel = 4'h0;
		rsp_ready = 1'b0;
	end

	// one request and its answer; stall holds the answer back that long
	task automatic fetch(input tcsd_block_t blk, input tcsd_format_t fmt,
		input logic [3:0] tx, input int stall, output int lat);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_block = blk;
		req_format = fmt;
		req_texel = tx;
		// prompt mode keeps ready up ahead of the answer
		rsp_ready = (stall == 0);
		while (req_ready !== 1'b1) begin
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		@(negedge clk_sys);
		// released fields carry junk so a stale copy cannot pass
		req_valid = 1'b0;
		req_block = ~blk;
		req_format = tcsd_format_t'(~fmt);
		req_texel = ~tx;
		lat = 1;
		while (rsp_valid !== 1'b1) begin
			@(negedge clk_sys);
			lat++;
		end
		repeat (stall) @(negedge clk_sys);
		rsp_ready = 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		rsp_ready = 1'b0;
	endtask
endmodule // tcsd_pipe_model
`default_nettype wire

/* File: sim/two_channel_signed_texel_block_decoder_test.sv */
// self-checking bench of the texel block decoder
`timescale 1ns/1ns
`default_nettype none
module two_channel_signed_texel_block_decoder_test;
	import tcsd_pkg::*;

	localparam int CYCLE_LIMIT = 20000; // far above the few thousand used
	logic clk_sys; // 125 MHz system clock
	logic rst; // synchronous reset
	logic req_valid, req_ready, rsp_ready, rsp_valid;
	tcsd_block_t req_block;
	tcsd_format_t req_format;
	logic [3:0] req_texel;
	logic [10:0] rsp_red_narrow, rsp_green_narrow;
	logic [15:0] rsp_red_wide16, rsp_green_wide16;
	logic [31:0] rsp_red_wide32, rsp_green_wide32;
	int errors = 0; // mismatches seen
	int checks_done = 0; // comparisons made
	int cycles = 0; // timeout counter
	int lat0 = -1; // latency of the first answer
	logic [10:0] last; // red result of the latest fetch

	// the decoder and its requesting pipeline
	tcsd_decoder u_dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_block(req_block), .req_format(req_format),
		.req_texel(req_texel), .rsp_ready(rsp_ready), .rsp_valid(rsp_valid),
		.rsp_red_narrow(rsp_red_narrow), .rsp_green_narrow(rsp_green_narrow),
		.rsp_red_wide16(rsp_red_wide16), .rsp_green_wide16(rsp_green_wide16),
		.rsp_red_wide32(rsp_red_wide32), .rsp_green_wide32(rsp_green_wide32));
	tcsd_pipe_model u_pipe (.clk_sys(clk_sys), .req_ready(req_ready),
		.req_valid(req_valid), .req_block(req_block), .req_format(req_format),
		.req_texel(req_texel), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

	// clock, 8 ns period
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// a hang counts as a mismatch and closes the run
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			errors++;
			finish_test();
		end
	end

	// expected 11-bit value of texel n of one word
	function automatic logic [10:0] exp_narrow(input logic [63:0] w,
		input logic sgn, input logic [3:0] n);
		int b, m, s, mu;
		logic [2:0] i;
		logic [15:0] row;
		i = w[47-3*n -: 3];
		row = TCSD_MAGS[w[51:48]];
		m = int'(row[15-4*i[1:0] -: 4]);
		m = i[2] ? m - 1 : -m;
		mu = int'(w[55:52]);
		// zero multiplier means one eighth, cancelling the scale
		if (mu != 0) begin
			m = m * mu * 8;
		end
		if (sgn) begin
			b = int'($signed(w[63:56]));
			if (b == -128) begin
				b = -127;
			end
			s = b * 8 + m;
			s = (s > 1023) ? 1023 : (s < -1023) ? -1023 : s;
		end else begin
			s = int'(w[63:56]) * 8 + 4 + m;
			s = (s > 2047) ? 2047 : (s < 0) ? 0 : s;
		end
		return 11'(s);
	endfunction

	// expected widened copy; signed goes through the magnitude
	function automatic logic [31:0] exp_wide(input logic [10:0] x,
		input logic sgn, input bit w32);
		int v;
		logic [9:0] mm;
		logic [31:0] r;
		v = sgn ? int'($signed(x)) : int'(x);
		if (!sgn) begin
			r = w32 ? {x, x, x[10:1]} : 32'((v << 5) + (v >> 6));
		end else begin
			mm = 10'((v < 0) ? -v : v);
			r = w32 ? {1'b0, mm, mm, mm, mm[9]} :
				32'((int'(mm) << 5) + (int'(mm) >> 5));
			if (v < 0) begin
				r = -r;
			end
		end
		return w32 ? r : {16'h0, r[15:0]};
	endfunction

	// block word with one chosen index at texel n
	function automatic logic [63:0] mk(input logic [7:0] b, input logic [3:0] mu,
		input logic [3:0] sel, input logic [3:0] n, input logic [2:0] idx);
		logic [63:0] w;
		w = {b, mu, sel, 48'h0};
		w[47-3*n -: 3] = idx;
		return w;
	endfunction

	task automatic chk_narrow(input logic [10:0] got, input logic [10:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_wide(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_lat(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// send both words as bytes, first byte most significant, then compare
	task automatic run(input logic [63:0] w0, input logic [63:0] w1,
		input tcsd_format_t f, input logic [3:0] n, input int stall);
		tcsd_block_t blk;
		int lat;
		logic [10:0] er, eg;
		for (int i = 0; i < 8; i++) begin
			blk[i] = w0[63-8*i -: 8];
			blk[8+i] = w1[63-8*i -: 8];
		end
		u_pipe.fetch(blk, f, n, stall, lat);
		if (lat0 < 0) begin
			lat0 = lat;
		end
		er = exp_narrow(w0, f[0], n);
		eg = f[1] ? exp_narrow(w1, f[0], n) : 11'h000;
		// answer three edges after the taking edge, fixed
		chk_lat(lat, 3);
		chk_narrow(rsp_red_narrow, er);
		chk_narrow(rsp_green_narrow, eg);
		chk_wide({16'h0, rsp_red_wide16}, exp_wide(er, f[0], 1'b0));
		chk_wide({16'h0, rsp_green_wide16}, exp_wide(eg, f[0], 1'b0));
		chk_wide(rsp_red_wide32, exp_wide(er, f[0], 1'b1));
		chk_wide(rsp_green_wide32, exp_wide(eg, f[0], 1'b1));
		last = rsp_red_narrow;
	endtask

	// counts, verdict and end of run
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// main sequence: worked cases, boundaries, then random blocks
	initial begin
		logic [63:0] ra;
		rst = 1'b1;
		void'($urandom(58592));
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_wide({20'h0, rsp_red_narrow, req_ready}, 32'h0);
		rst = 1'b0;
		ra = {$urandom, $urandom};
		run(mk(8'h3c, 4'h2, 4'hd, 4'h1, 3'h3), ra, one_channel_signed_format, 4'h1, 0);
		chk_narrow(last, 11'h140);
		run(mk(8'h3c, 4'h0, 4'hd, 4'h1, 3'h3), ra, one_channel_signed_format, 4'h1, 3);
		chk_narrow(last, 11'h1d6);
		run(mk(8'h67, 4'h2, 4'hd, 4'h1, 3'h3), ra, one_channel_unsigned_format, 4'h1, 0);
		chk_narrow(last, 11'h29c);
		chk_wide({16'h0, rsp_red_wide16}, 32'h538a);
		run(mk(8'h67, 4'h0, 4'hd, 4'h1, 3'h3), ra, one_channel_unsigned_format, 4'h1, 1);
		chk_narrow(last, 11'h332);
		// -59*8 plus entry 2 gives -470, widened through the magnitude
		run(mk(8'hc5, 4'h0, 4'hd, 4'h2, 3'h6), ra,
			one_channel_signed_format, 4'h2, 0);
		chk_narrow(last, 11'h62a);
		chk_wide({16'h0, rsp_red_wide16}, 32'hc532);
		run(mk(8'h80, 4'h0, 4'hd, 4'h5, 3'h4), ra, one_channel_signed_format, 4'h5, 0);
		chk_narrow(last, 11'h408);
		run(mk(8'h7f, 4'hf, 4'hd, 4'h0, 3'h7), ra, one_channel_signed_format, 4'h0, 0);
		chk_narrow(last, 11'h3ff);
		run(mk(8'h81, 4'hf, 4'hd, 4'hf, 3'h3), ra, one_channel_signed_format, 4'hf, 2);
		chk_narrow(last, 11'h401);
		run(mk(8'hff, 4'hf, 4'hd, 4'h0, 3'h7), ra, one_channel_unsigned_format, 4'h0, 0);
		chk_narrow(last, 11'h7ff);
		run(mk(8'h00, 4'hf, 4'hd, 4'h0, 3'h3), ra, two_channel_unsigned_format, 4'h0, 0);
		chk_narrow(last, 11'h000);
		// every table, texel position and format, with answer stalls of 0 to 2 cycles
		for (int k = 0; k < 320; k++) begin
			ra = {$urandom, $urandom};
			ra[51:48] = 4'(k);
			run(ra, {$urandom, $urandom}, tcsd_format_t'(k % 4), 4'(k / 16),
				$urandom_range(2, 0));
		end
		finish_test();
	end
endmodule // two_channel_signed_texel_block_decoder_test
`default_nettype wire
